/* pkg/dlic_pkg.sv */
package dlic_pkg;

  localparam int unsigned DLIC_AW = 32;
  localparam int unsigned DLIC_DW = 32;
  localparam int unsigned DLIC_NSRC = 32;

  // Byte addresses of the register map
  localparam logic [31:0] DLIC_OFS_NORMAL_ACTIVE_STATUS    = 32'hffff_0000;
  localparam logic [31:0] DLIC_OFS_NORMAL_RAW_SIGNAL       = 32'hffff_0004;
  localparam logic [31:0] DLIC_OFS_NORMAL_ENABLE_MASK      = 32'hffff_0008;
  localparam logic [31:0] DLIC_OFS_NORMAL_MASK_CLEAR       = 32'hffff_000c;
  localparam logic [31:0] DLIC_OFS_NESTING_CONTROL         = 32'hffff_0010;
  localparam logic [31:0] DLIC_OFS_VECTOR_TABLE_BASE       = 32'hffff_0014;
  localparam logic [31:0] DLIC_OFS_VECTOR_READ             = 32'hffff_001c;
  localparam logic [31:0] DLIC_OFS_PRIORITY_WORD_FIRST     = 32'hffff_0020;
  localparam logic [31:0] DLIC_OFS_PRIORITY_WORD_SECOND    = 32'hffff_0024;
  localparam logic [31:0] DLIC_OFS_PRIORITY_WORD_THIRD     = 32'hffff_0028;
  localparam logic [31:0] DLIC_OFS_FAST_ACTIVE_STATUS      = 32'hffff_0100;
  localparam logic [31:0] DLIC_OFS_FAST_RAW_SIGNAL         = 32'hffff_0104;
  localparam logic [31:0] DLIC_OFS_FAST_ENABLE_MASK        = 32'hffff_0108;
  localparam logic [31:0] DLIC_OFS_FAST_MASK_CLEAR         = 32'hffff_010c;
  localparam logic [31:0] DLIC_OFS_SOFTWARE_REQUEST_CONFIG = 32'hffff_0110;

  localparam logic [31:0] DLIC_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] DLIC_RST_BASE = 16'h0000;
  localparam logic [1:0]  DLIC_RST_NEST = 2'h0;
  localparam logic [2:0]  DLIC_RST_PRIO = 3'h0;

  // Fields
  localparam int unsigned DLIC_SWR_NORMAL_BIT = 1;
  localparam int unsigned DLIC_SWR_FAST_BIT   = 2;
  localparam int unsigned DLIC_SRC_SOFT       = 1;
  localparam int unsigned DLIC_NEST_NORMAL    = 0;
  localparam int unsigned DLIC_NEST_FAST      = 1;
  localparam int unsigned DLIC_VEC_SRC_LSB    = 2;
  localparam int unsigned DLIC_VEC_BASE_LSB   = 7;
  localparam int unsigned DLIC_PRIO_WORDS     = 4;
  localparam int unsigned DLIC_PRIO_FIELD_W   = 4;

  typedef struct packed {
    logic [31:0] active_status;
    logic [31:0] raw_signal;
    logic [31:0] enable_mask;
  } dlic_level_t;

  typedef struct packed {
    dlic_level_t  normal;
    dlic_level_t  fast;
    logic [2:0]   swr;
    logic [1:0]   nest;
    logic [15:0]  base;
    logic [95:0]  prio;
    logic [4:0]   top_src;
    logic         irq;
    logic         fiq;
    logic         waitreq;
    logic         rvalid;
    logic [31:0]  rdata;
  } dlic_state_t;

endpackage : dlic_pkg

/* src/dlic_top.sv */
// Operation
// - Normal request output is OR of all 32 normal active status bits.
// - Normal raw bits follow peripheral request lines; register is read-only.
// - Normal enable bit 1 lets source raise normal request; 0 masks it.
// - Writing zeros to an enable mask never clears bits; writes only set.
// - Normal mask-clear write clears enable bits written as 1, others kept.
// - Normal active status equals normal raw AND normal enable.
// - Standard mode has no priority encoding; software reads active status. Code still gives the lowest active bit as top normal source.
// - Fast request is OR of fast active bits 31..1, also drives bit 0.
// - Setting a bit in one level's enable clears it in the other.
// - Fast raw bits follow fast peripheral lines; register is read-only.
// - Fast enable bit 1 lets source raise fast request; 0 masks it.
// - Fast mask-clear write clears fast enable bits written as 1.
// - Fast active status equals fast raw AND fast enable.
// - Programmed requests bypass masks into raw and active of chosen level.
// - Software request bit 1 drives normal raw and active bit 1.
// - Software request bit 2 drives fast raw and active bit 1.
// - Nesting control bit 0 enables vectored normal, bit 1 vectored fast.
// - Vectored mode nests eight levels per level; fast outranks normal.
// - Each source has a programmable priority 0 to 7 in priority words.
// - Vector base holds 16-bit base in bits 15:0; upper bits read zero.
// - Each bit is a fixed source; bit 1 software, bit 0 fast OR.
// - Vector read gives base in 22:7 and top normal source in 6:2.
`timescale 1ns/1ps
module dlic_top #(
  parameter int unsigned NSRC = dlic_pkg::DLIC_NSRC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [31:0] NORMAL_SRC,
  input  wire logic [31:0] FAST_SRC,
  input  wire logic [31:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ_OUT,
  output logic             FIQ_OUT,
  output logic             NEST_NORMAL_EN,
  output logic             NEST_FAST_EN,
  output logic      [4:0]  TOP_NORMAL_SRC
);

  dlic_pkg::dlic_state_t s_q;
  dlic_pkg::dlic_state_t s_d;

  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] n_raw;
  logic [31:0] f_raw;
  logic [31:0] n_act;
  logic [31:0] f_act;
  logic        f_or;
  logic        acc;
  logic [31:0] rd;
  logic [31:0] n_gated;
  logic [31:0] f_gated;

  // Normal and fast mask gate; bits 1 and 0 are fixed sources, driven elsewhere without a mask
  for (genvar g = 0; g < 32; g++) begin : g_src
    if (g < 2) begin : g_fixed
      assign n_gated[g] = 1'b0;
      assign f_gated[g] = 1'b0;
    end else begin : g_line
      assign n_gated[g] = NORMAL_SRC[g] & s_q.normal.enable_mask[g];
      assign f_gated[g] = FAST_SRC[g] & s_q.fast.enable_mask[g];
    end
  end

  // Byte enables expanded to a bit mask
  function automatic logic [31:0] dlic_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : dlic_be_mask

  function automatic logic dlic_hit(input logic [31:0] a, input logic [31:0] ofs);
    return a == ofs;
  endfunction : dlic_hit

  // Three-bit priority of a source from the packed priority words
  function automatic logic [2:0] dlic_prio(input logic [95:0] p, input int unsigned src);
    return p[src*3 +: 3];
  endfunction : dlic_prio

  // Highest priority active source when vec is set, else lowest active bit; 7 is most urgent, ties go to lowest bit
  function automatic logic [4:0] dlic_pick(input logic [31:0] act, input logic [95:0] p, input logic vec);
    logic [4:0] best;
    logic [2:0] bp;
    logic       found;
    best  = 5'h00;
    bp    = 3'h0;
    found = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (act[i] && (!found || (vec && dlic_prio(p, i) > bp))) begin
        best  = 5'(i);
        bp    = dlic_prio(p, i);
        found = 1'b1;
      end
    end
    return best;
  endfunction : dlic_pick

  always_comb begin
    s_d  = s_q;
    acc  = (AVS_READ || AVS_WRITE) && s_q.waitreq;
    wmask = dlic_be_mask(AVS_BYTEENABLE);
    wval  = AVS_WRITEDATA & wmask;

    // Bit 1 software, bit 0 fast OR
    n_raw = NORMAL_SRC;
    n_raw[dlic_pkg::DLIC_SRC_SOFT] = s_q.swr[dlic_pkg::DLIC_SWR_NORMAL_BIT];
    f_raw = FAST_SRC;
    f_raw[dlic_pkg::DLIC_SRC_SOFT] = s_q.swr[dlic_pkg::DLIC_SWR_FAST_BIT];

    f_act = f_gated;
    f_act[dlic_pkg::DLIC_SRC_SOFT] = f_raw[dlic_pkg::DLIC_SRC_SOFT];
    f_or = |f_act[31:1];
    f_act[0] = f_or;
    f_raw[0] = f_or;
    n_raw[0] = f_or;

    n_act = n_gated;
    n_act[dlic_pkg::DLIC_SRC_SOFT] = n_raw[dlic_pkg::DLIC_SRC_SOFT];
    n_act[0] = f_or;

    s_d.normal.raw_signal    = n_raw;
    s_d.normal.active_status = n_act;
    s_d.fast.raw_signal      = f_raw;
    s_d.fast.active_status   = f_act;
    s_d.irq = |n_act;
    s_d.fiq = f_or;

    s_d.top_src = dlic_pick(n_act, s_q.prio, s_q.nest[dlic_pkg::DLIC_NEST_NORMAL]);

    s_d.waitreq = !acc;
    s_d.rvalid  = 1'b0;

    rd = dlic_pkg::DLIC_RST_WORD;
    unique case (AVS_ADDRESS)
      dlic_pkg::DLIC_OFS_NORMAL_ACTIVE_STATUS:    rd = s_q.normal.active_status;
      dlic_pkg::DLIC_OFS_NORMAL_RAW_SIGNAL:       rd = s_q.normal.raw_signal;
      dlic_pkg::DLIC_OFS_NORMAL_ENABLE_MASK:      rd = s_q.normal.enable_mask;
      dlic_pkg::DLIC_OFS_NESTING_CONTROL:         rd = {30'h0000_0000, s_q.nest};
      dlic_pkg::DLIC_OFS_VECTOR_TABLE_BASE:       rd = {16'h0000, s_q.base};
      dlic_pkg::DLIC_OFS_VECTOR_READ:             rd = {9'h000, s_q.base, s_q.top_src, 2'h0};
      dlic_pkg::DLIC_OFS_PRIORITY_WORD_FIRST:     rd = s_q.prio[31:0];
      dlic_pkg::DLIC_OFS_PRIORITY_WORD_SECOND:    rd = s_q.prio[63:32];
      dlic_pkg::DLIC_OFS_PRIORITY_WORD_THIRD:     rd = s_q.prio[95:64];
      dlic_pkg::DLIC_OFS_FAST_ACTIVE_STATUS:      rd = s_q.fast.active_status;
      dlic_pkg::DLIC_OFS_FAST_RAW_SIGNAL:         rd = s_q.fast.raw_signal;
      dlic_pkg::DLIC_OFS_FAST_ENABLE_MASK:        rd = s_q.fast.enable_mask;
      dlic_pkg::DLIC_OFS_SOFTWARE_REQUEST_CONFIG: rd = {29'h0000_0000, s_q.swr};
      default:                                    rd = dlic_pkg::DLIC_RST_WORD;
    endcase
    if (acc && AVS_READ) begin
      s_d.rdata = rd;
    end

    if (acc && AVS_WRITE) begin
      case (AVS_ADDRESS)
        dlic_pkg::DLIC_OFS_NORMAL_ENABLE_MASK: begin
          s_d.normal.enable_mask = s_q.normal.enable_mask | wval;
          s_d.fast.enable_mask   = s_q.fast.enable_mask & ~wval;
        end
        dlic_pkg::DLIC_OFS_FAST_ENABLE_MASK: begin
          s_d.fast.enable_mask   = s_q.fast.enable_mask | wval;
          s_d.normal.enable_mask = s_q.normal.enable_mask & ~wval;
        end
        dlic_pkg::DLIC_OFS_NORMAL_MASK_CLEAR: begin
          s_d.normal.enable_mask = s_q.normal.enable_mask & ~wval;
        end
        dlic_pkg::DLIC_OFS_FAST_MASK_CLEAR: begin
          s_d.fast.enable_mask = s_q.fast.enable_mask & ~wval;
        end
        dlic_pkg::DLIC_OFS_NESTING_CONTROL: begin
          s_d.nest = (s_q.nest & ~wmask[1:0]) | wval[1:0];
        end
        dlic_pkg::DLIC_OFS_VECTOR_TABLE_BASE: begin
          s_d.base = (s_q.base & ~wmask[15:0]) | wval[15:0];
        end
        dlic_pkg::DLIC_OFS_PRIORITY_WORD_FIRST: begin
          s_d.prio[31:0] = (s_q.prio[31:0] & ~wmask) | wval;
        end
        dlic_pkg::DLIC_OFS_PRIORITY_WORD_SECOND: begin
          s_d.prio[63:32] = (s_q.prio[63:32] & ~wmask) | wval;
        end
        dlic_pkg::DLIC_OFS_PRIORITY_WORD_THIRD: begin
          s_d.prio[95:64] = (s_q.prio[95:64] & ~wmask) | wval;
        end
        dlic_pkg::DLIC_OFS_SOFTWARE_REQUEST_CONFIG: begin
          s_d.swr = (s_q.swr & ~wmask[2:0]) | (wval[2:0] & 3'h6);
        end
        default: begin
          s_d.swr = s_q.swr;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q         <= '0;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA    = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.waitreq;
  assign IRQ_OUT         = s_q.irq;
  assign FIQ_OUT         = s_q.fiq;
  assign NEST_NORMAL_EN  = s_q.nest[dlic_pkg::DLIC_NEST_NORMAL];
  assign NEST_FAST_EN    = s_q.nest[dlic_pkg::DLIC_NEST_FAST];
  assign TOP_NORMAL_SRC  = s_q.top_src;

endmodule : dlic_top

/* dv/dlic_core_model.sv */
`timescale 1ns/1ps
// Core side: counts entries into each exception mode on request rising edges
module dlic_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic irq,
  input  wire logic fiq,
  output int        n_irq,
  output int        n_fiq
);
  logic irq_q, fiq_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      fiq_q <= 1'b0;
      n_irq <= 0;
      n_fiq <= 0;
    end else begin
      irq_q <= irq;
      fiq_q <= fiq;
      n_irq <= n_irq + int'(irq && !irq_q);
      n_fiq <= n_fiq + int'(fiq && !fiq_q);
    end
  end
endmodule : dlic_core_model

/* dv/dlic_monitor.sv */
`timescale 1ns/1ps
module dlic_monitor (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [31:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        NEST_NORMAL_EN,
  input wire logic        NEST_FAST_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence rd_at(logic [31:0] a);
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == a;
  endsequence
  AST_WAIT_ANS: assert property (req |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer held too long");
  AST_WAIT_CAUSE: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");
  AST_BASE_HI: assert property (rd_at(32'hffff_0014) |=> AVS_READDATA[31:16] == 16'h0000)
    else $error("base upper bits not zero");
  AST_SWR_RSVD: assert property (rd_at(32'hffff_0110) |=> AVS_READDATA[31:3] == 29'h0 && !AVS_READDATA[0])
    else $error("software request reserved bits set");
  AST_VEC_RSVD: assert property (rd_at(32'hffff_001c) |=> AVS_READDATA[31:23] == 9'h000 && AVS_READDATA[1:0] == 2'h0)
    else $error("vector read reserved bits set");
  AST_UNMAPPED: assert property (rd_at(32'hffff_0018) |=> AVS_READDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_NEST_SRC: assert property (!$stable({NEST_NORMAL_EN, NEST_FAST_EN}) |->
    $past(AVS_WRITE && AVS_ADDRESS == 32'hffff_0010) || $past(AVS_WRITE && AVS_ADDRESS == 32'hffff_0010, 2))
    else $error("nesting outputs changed without write");
endmodule : dlic_monitor
bind dlic_top dlic_monitor i_mon (.CLOCK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
  .AVS_WAITREQUEST, .NEST_NORMAL_EN, .NEST_FAST_EN);

/* dv/dual_level_interrupt_controller_tb_top.sv */
`timescale 1ns/1ps
module dual_level_interrupt_controller_tb_top;
  localparam logic [31:0] P = 32'hffff_0000;
  localparam logic [31:0] M = 32'hffff_fffc;
  logic CLOCK, RST_N, rd, wr, wt, irq, fiq, nn, nf, fo;
  logic [31:0] ns, fs, adr, wd, q, rdat, ne, fe, na, fa;
  logic [4:0] top;
  logic [2:0] sw;
  logic [3:0] be;
  int failures, n_checks, seed, ncnt, fcnt;
  int cyc = 0;
  int ro [9] = '{0, 4, 8, 20, 28, 256, 260, 264, 272};
  dlic_top i_dut (.CLOCK, .RST_N, .NORMAL_SRC(ns), .FAST_SRC(fs), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt),
    .IRQ_OUT(irq), .FIQ_OUT(fiq), .NEST_NORMAL_EN(nn), .NEST_FAST_EN(nf), .TOP_NORMAL_SRC(top));
  dlic_core_model i_core (.clk(CLOCK), .rst_n(RST_N), .irq(irq), .fiq(fiq), .n_irq(ncnt), .n_fiq(fcnt));
  initial begin
    CLOCK = 0;
    forever #4 CLOCK = ~CLOCK;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until the edge that sees waitrequest low; gap edge avoids a double drive
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge CLOCK);
    end while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge CLOCK);
  endtask : bus
  task automatic rdchk(string nm, logic [31:0] a, logic [31:0] e);
    bus(1'b0, a, 0);
    chk(nm, e, q);
  endtask : rdchk
  initial begin
    seed = 32'h9fb37a76;
    {failures, n_checks} = 0;
    {RST_N, rd, wr, adr, wd, ns, fs} = 0;
    be = 4'hf;
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    foreach (ro[i]) rdchk("reset", P + ro[i], 0);
    $display("test reset done");
    ne = $random(seed) & M;
    bus(1, P + 8, ne);
    bus(1, P + 8, 0);
    rdchk("normal_enable", P + 8, ne);
    bus(1, P + 12, 32'h0000_ff00);
    ne &= 32'hffff_00ff;
    rdchk("normal_enable", P + 8, ne);
    fe = $random(seed) & M;
    bus(1, P + 264, fe);
    rdchk("normal_enable", P + 8, ne & ~fe);
    bus(1, P + 268, 32'hff00_0000);
    rdchk("fast_enable", P + 264, fe & 32'h00ff_ffff);
    $display("test masks done");
    repeat (8) begin
      ns <= 0;
      fs <= 0;
      // Enables cleared only while the NORMAL_SRC and FAST_SRC lines are idle
      bus(1, P + 12, '1);
      bus(1, P + 268, '1);
      ne = $random(seed) & M;
      fe = $random(seed) & M;
      sw = 3'($random(seed)) & 3'h6;
      bus(1, P + 8, ne);
      bus(1, P + 264, fe);
      bus(1, P + 272, sw);
      ne &= ~fe;
      ns <= $random(seed);
      fs <= $random(seed);
      repeat (3) @(posedge CLOCK);
      fa = (fs & fe & M) | {sw[2], 1'b0};
      fo = |fa[31:1];
      fa[0] = fo;
      na = ({ns[31:2], sw[1], fo} & ne) | {sw[1], fo};
      rdchk("normal_raw", P + 4, {ns[31:2], sw[1], fo});
      rdchk("normal_active", P, na);
      rdchk("fast_raw", P + 260, {fs[31:2], sw[2], fo});
      rdchk("fast_active", P + 256, fa);
      rdchk("software_request", P + 272, sw);
      chk("irq_out", |na, irq);
      chk("fiq_out", fo, fiq);
    end
    $display("test random done");
    bus(1, P + 20, '1);
    rdchk("vector_base", P + 20, 32'h0000_ffff);
    bus(1, P + 24, '1);
    rdchk("unmapped", P + 24, 0);
    ns <= 0;
    fs <= 0;
    bus(1, P + 272, 0);
    bus(1, P + 12, '1);
    bus(1, P + 268, '1);
    bus(1, P + 8, 32'h0000_0220);
    ns <= 32'h0000_0220;
    bus(1, P + 16, 1);
    chk("nesting", 1, {nf, nn});
    rdchk("vector_read", P + 28, 32'h007f_ff94);
    chk("top_source", 5, top);
    bus(1, P + 32, 32'h3800_0000);
    rdchk("vector_read", P + 28, 32'h007f_ffa4);
    chk("top_source", 9, top);
    be <= 4'h2;
    bus(1, P + 20, 0);
    be <= 4'hf;
    rdchk("vector_base", P + 20, 32'h0000_00ff);
    chk("core_requests", 1, ncnt > 0);
    $display("test vector done");
    report_and_stop();
  end
endmodule : dual_level_interrupt_controller_tb_top
